/* File: design/iod_top.sv */
`timescale 1ns/1ps
/*
  iod_top: instruction decoder with product pair, leading-count unit and
  atomic bit sequencer for the integer pipeline.
  assumes: fetch gives one aligned word per i_valid; data port answers
  reads with i_mem_ack and accepts writes in the one cycle they are asked, without an ack.
*/
// Function
// - clz counts leading zeros, 32 if zero
// - signed multiply-add into product pair
// - unsigned multiply-add into product pair
// - signed multiply-subtract from product pair
// - unsigned multiply-subtract from product pair
// - multiply ops never raise arithmetic exceptions
// - mul_to_gpr writes low 32 product bits
// - superscalar_nop behaves as plain nop
// - atomic clear bit, uninterruptible byte rmw
// - atomic set bit, uninterruptible byte rmw
// - interrupt_return restores state, may chain
// - primary opcode row/column map
// - reserved and coprocessor-unusable exceptions
// - function_group row/column decode
// - ext_group_two function decode
// - udi rows optional, else reserved
// - ext_group_three decode, rest reserved
// - reg_imm_group rt decode
// - user_coproc rs decode
// - coproc two branch condition bits
// - sys_coproc rs decode
// - sys_coproc function decode
module iod_top
  import iod_pkg::*;
#(
  parameter bit HAS_UDI = 1'b0,
  parameter bit HAS_CHAIN = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_valid,
  input wire logic [31:0] i_instr,
  input wire logic [31:0] i_src_a,
  input wire logic [31:0] i_src_b,
  input wire logic i_irq_pending,
  input wire logic [7:0] i_mem_rdata,
  input wire logic i_mem_ack,
  output logic o_ready,
  output iod_op_e o_op,
  output iod_exc_e o_exc,
  output logic [31:0] o_result,
  output logic o_result_we,
  output logic [31:0] o_prod_high,
  output logic [31:0] o_prod_low,
  output logic o_irq_block,
  output logic o_interrupt_return_restore,
  output logic o_interrupt_return_chain,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [7:0] o_mem_wdata
);
  logic [5:0] opc;
  logic [4:0] rs_f;
  logic [4:0] rt_f;
  logic [5:0] fn;
  iod_op_e op_dec;
  iod_exc_e exc_dec;
  logic mac_go;
  logic clz_pend_reg;
  logic mul_pend_reg;
  logic [5:0] clz_cnt;
  iod_at_e at_state_reg;
  logic at_set_reg;
  logic [2:0] at_bit_reg;
  logic [7:0] at_data_reg;
  logic is_atomic;

  assign opc = i_instr[OP_HI:OP_LO];
  assign rs_f = i_instr[RS_HI:RS_LO];
  assign rt_f = i_instr[RT_HI:RT_LO];
  assign fn = i_instr[FN_HI:FN_LO];

  always_comb begin
    op_dec = IOD_OP_NONE;
    exc_dec = IOD_EXC_NONE;
    case (opc)
      OPC_FUNC: begin
        case (fn)
          6'h00: op_dec = (i_instr == 32'h0 || i_instr == 32'h40) ? IOD_OP_NOP : IOD_OP_SLL;
          6'h02: op_dec = IOD_OP_SRL;
          6'h08: op_dec = IOD_OP_JR;
          6'h10: op_dec = IOD_OP_MFHI;
          6'h18: op_dec = IOD_OP_MULT;
          6'h20: op_dec = IOD_OP_ADD;
          6'h01: exc_dec = IOD_EXC_CPU;
          6'h05, 6'h0e, 6'h35, 6'h37: exc_dec = IOD_EXC_RSVD;
          default: begin
            if (fn[5:2] == 4'h5 || fn[5:2] == 4'h7 || fn[5:2] == 4'hb || fn[5:3] == 3'h7 ||
                fn[5:0] == 6'h28 || fn[5:0] == 6'h29 || fn[5:2] == 4'hb) begin
              exc_dec = IOD_EXC_RSVD;
            end else begin
              op_dec = IOD_OP_FUNC_OTHER;
            end
          end
        endcase
      end
      OPC_REG_IMM_GROUP: begin
        case (rt_f)
          5'h00: op_dec = IOD_OP_BLTZ;
          5'h01: op_dec = IOD_OP_BGEZ;
          5'h02: op_dec = IOD_OP_BLTZL;
          5'h03: op_dec = IOD_OP_BGEZL;
          5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0e: op_dec = IOD_OP_TRAPI;
          5'h10: op_dec = IOD_OP_BLTZAL;
          5'h11: op_dec = IOD_OP_BGEZAL;
          5'h12: op_dec = IOD_OP_BLTZALL;
          5'h13: op_dec = IOD_OP_BGEZALL;
          5'h1f: op_dec = IOD_OP_OTHER;
          default: exc_dec = IOD_EXC_RSVD;
        endcase
      end
      OPC_EXT2: begin
        case (fn)
          FN2_MUL_ADD_SIGNED: op_dec = IOD_OP_MUL_ADD_SIGNED;
          FN2_MUL_ADD_UNSIGNED: op_dec = IOD_OP_MUL_ADD_UNSIGNED;
          FN2_MUL: op_dec = IOD_OP_MUL;
          FN2_MUL_SUB_SIGNED: op_dec = IOD_OP_MUL_SUB_SIGNED;
          FN2_MUL_SUB_UNSIGNED: op_dec = IOD_OP_MUL_SUB_UNSIGNED;
          FN2_CLZ: op_dec = IOD_OP_CLZ;
          FN2_CLO: op_dec = IOD_OP_CLO;
          FN2_DBG: op_dec = IOD_OP_DBGBRK;
          default: begin
            if (HAS_UDI && fn[UDI_ROW_HI:UDI_ROW_LO] == FN2_UDI_ROW) begin
              op_dec = IOD_OP_UDI;
            end else begin
              exc_dec = IOD_EXC_RSVD;
            end
          end
        endcase
      end
      OPC_EXT3: begin
        case (fn)
          FN3_EXTR: op_dec = IOD_OP_EXTR;
          FN3_INSR: op_dec = IOD_OP_INSR;
          FN3_SHUF: op_dec = IOD_OP_SHUF;
          FN3_HWRD: op_dec = IOD_OP_HWRD;
          default: exc_dec = IOD_EXC_RSVD;
        endcase
      end
      OPC_USRCP: begin
        if (rs_f[4]) begin
          op_dec = IOD_OP_USER_COPROC;
        end else if (rs_f[3]) begin
          case ({i_instr[CC_BIT_LIKELY], i_instr[CC_BIT_TRUE]})
            2'h0: op_dec = IOD_OP_BC2F;
            2'h1: op_dec = IOD_OP_BC2T;
            2'h2: op_dec = IOD_OP_BC2FL;
            default: op_dec = IOD_OP_BC2TL;
          endcase
        end else begin
          case (rs_f)
            5'h00: op_dec = IOD_OP_MFC2;
            5'h02: op_dec = IOD_OP_CFC2;
            5'h03: op_dec = IOD_OP_MFHC2;
            5'h04: op_dec = IOD_OP_MTC2;
            5'h06: op_dec = IOD_OP_CTC2;
            5'h07: op_dec = IOD_OP_MTHC2;
            default: exc_dec = IOD_EXC_RSVD;
          endcase
        end
      end
      OPC_SYSCP: begin
        if (rs_f[4]) begin
          case (fn)
            FN0_TLBRD: op_dec = IOD_OP_TLBR;
            FN0_TLBWI: op_dec = IOD_OP_TLBWI;
            FN0_TLBWRN: op_dec = IOD_OP_TLBWR;
            FN0_TLBPR: op_dec = IOD_OP_TLBP;
            FN0_EXRET: op_dec = IOD_OP_EXCEPTION_RETURN;
            FN0_INTACK: op_dec = IOD_OP_INTERRUPT_RETURN;
            FN0_DBRET: op_dec = IOD_OP_DEBUG_RETURN;
            FN0_WAIT: op_dec = IOD_OP_WAIT;
            default: exc_dec = IOD_EXC_RSVD;
          endcase
        end else begin
          case (rs_f)
            5'h00: op_dec = IOD_OP_MFC0;
            5'h04: op_dec = IOD_OP_MTC0;
            5'h0a: op_dec = IOD_OP_RDPGPR;
            5'h0b: op_dec = IOD_OP_INTEN;
            5'h0e: op_dec = IOD_OP_WRPGPR;
            default: exc_dec = IOD_EXC_RSVD;
          endcase
        end
      end
      OPC_CP1, OPC_CP3, 6'h31, 6'h35, 6'h39, 6'h3d: exc_dec = IOD_EXC_CPU;
      6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1e, 6'h27, 6'h2c, 6'h2d,
      6'h34, 6'h36, 6'h37, 6'h3b, 6'h3c, 6'h3e, 6'h3f: exc_dec = IOD_EXC_RSVD;
      default: op_dec = IOD_OP_OTHER;
    endcase
  end

  // atomics ride on ext_group_three function 0x3c/0x3d
  assign is_atomic = i_valid && o_ready && (opc == OPC_EXT3) && (fn == 6'h3c || fn == 6'h3d);
  // blocks interrupts from the accept cycle on, not only once the read is out
  assign o_ready = (at_state_reg == IOD_AT_IDLE) && !clz_pend_reg;

  assign mac_go = i_valid && o_ready && (op_dec == IOD_OP_MUL_ADD_SIGNED || op_dec == IOD_OP_MUL_ADD_UNSIGNED ||
                  op_dec == IOD_OP_MUL_SUB_SIGNED || op_dec == IOD_OP_MUL_SUB_UNSIGNED || op_dec == IOD_OP_MUL ||
                  op_dec == IOD_OP_MULT);

  iod_mac u_mac (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_go(mac_go),
    .i_signed(op_dec != IOD_OP_MUL_ADD_UNSIGNED && op_dec != IOD_OP_MUL_SUB_UNSIGNED),
    .i_sub(op_dec == IOD_OP_MUL_SUB_SIGNED || op_dec == IOD_OP_MUL_SUB_UNSIGNED),
    .i_acc(op_dec != IOD_OP_MUL && op_dec != IOD_OP_MULT),
    .i_a(i_src_a),
    .i_b(i_src_b),
    .o_hi(o_prod_high),
    .o_lo(o_prod_low)
  );

  iod_clz u_clz (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_word(i_src_a),
    .i_ones(op_dec == IOD_OP_CLO),
    .o_count(clz_cnt)
  );

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_op <= IOD_OP_NONE;
      o_exc <= IOD_EXC_NONE;
      clz_pend_reg <= 1'b0;
      mul_pend_reg <= 1'b0;
    end else begin
      // superscalar_nop reported as nop, no stall
      o_op <= (i_valid && o_ready) ? op_dec : IOD_OP_NONE;
      o_exc <= (i_valid && o_ready) ? exc_dec : IOD_EXC_NONE;
      clz_pend_reg <= i_valid && o_ready && (op_dec == IOD_OP_CLZ || op_dec == IOD_OP_CLO);
      mul_pend_reg <= i_valid && o_ready && op_dec == IOD_OP_MUL;
    end
  end

  // count result, else low word of product, to dest
  always_comb begin
    o_result_we = clz_pend_reg || mul_pend_reg;
    if (clz_pend_reg) begin
      o_result = {26'h0, clz_cnt};
    end else if (mul_pend_reg) begin
      o_result = o_prod_low;
    end else begin
      o_result = 32'h0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_interrupt_return_restore <= 1'b0;
      o_interrupt_return_chain <= 1'b0;
    end else begin
      o_interrupt_return_restore <= i_valid && o_ready && op_dec == IOD_OP_INTERRUPT_RETURN;
      o_interrupt_return_chain <= i_valid && o_ready && op_dec == IOD_OP_INTERRUPT_RETURN && HAS_CHAIN && i_irq_pending;
    end
  end

  // atomic sequencer holds interrupts off read to write
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      at_state_reg <= IOD_AT_IDLE;
      at_set_reg <= 1'b0;
      at_bit_reg <= 3'h0;
      at_data_reg <= 8'h00;
    end else begin
      case (at_state_reg)
        IOD_AT_IDLE: begin
          // a refused word must not start a read
          if (is_atomic) begin
            at_state_reg <= IOD_AT_READ;
            at_set_reg <= fn[0];
            at_bit_reg <= i_instr[RD_LO+2:RD_LO];
          end
        end
        IOD_AT_READ: begin
          if (i_mem_ack) begin
            at_data_reg <= at_set_reg ? (i_mem_rdata | (8'h01 << at_bit_reg)) :
                           (i_mem_rdata & ~(8'h01 << at_bit_reg));
            at_state_reg <= IOD_AT_WRITE;
          end
        end
        IOD_AT_WRITE: at_state_reg <= IOD_AT_IDLE;
        default: at_state_reg <= IOD_AT_IDLE;
      endcase
    end
  end

  assign o_irq_block = (at_state_reg != IOD_AT_IDLE) || is_atomic;
  assign o_mem_rd = (at_state_reg == IOD_AT_READ);
  assign o_mem_wr = (at_state_reg == IOD_AT_WRITE);
  assign o_mem_wdata = at_data_reg;

  a_clz_zero: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_valid && o_ready && op_dec == IOD_OP_CLZ && i_src_a == 32'h0 |=> o_result == 32'h20)
    else $error("clz of zero not 32");
  a_mul_add_signed_sum: assert property (@(posedge i_clk) disable iff (!i_nrst)
    mac_go && op_dec == IOD_OP_MUL_ADD_SIGNED |=> {o_prod_high, o_prod_low} ==
    $past({o_prod_high, o_prod_low}) + 64'($signed($past(i_src_a)) * $signed($past(i_src_b))))
    else $error("signed accumulate wrong");
  a_mul_sub_signed_diff: assert property (@(posedge i_clk) disable iff (!i_nrst)
    mac_go && op_dec == IOD_OP_MUL_SUB_SIGNED |=> {o_prod_high, o_prod_low} ==
    $past({o_prod_high, o_prod_low}) - 64'($signed($past(i_src_a)) * $signed($past(i_src_b))))
    else $error("signed subtract wrong");
  a_mul_noexc: assert property (@(posedge i_clk) disable iff (!i_nrst)
    mac_go |=> o_exc == IOD_EXC_NONE)
    else $error("exception on multiply");
  a_cop_unusable: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_valid && o_ready && (opc == OPC_CP1 || opc == OPC_CP3) |=> o_exc == IOD_EXC_CPU)
    else $error("missing coprocessor unusable");
  a_udi_rsvd: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_valid && o_ready && !HAS_UDI && opc == OPC_EXT2 && fn[5:4] == 2'h1 |=> o_exc == IOD_EXC_RSVD)
    else $error("udi row not reserved");
  a_atomic_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_mem_rd && i_mem_ack |=> o_mem_wr && o_irq_block)
    else $error("interrupt window in atomic");
  a_nop_nostall: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_op == IOD_OP_NOP |-> o_ready)
    else $error("nop stalled");
  a_mul_low: assert property (@(posedge i_clk) disable iff (!i_nrst)
    mac_go && op_dec == IOD_OP_MUL |=> o_result_we &&
    o_result == 32'($signed($past(i_src_a)) * $signed($past(i_src_b))))
    else $error("mul low word missing");

  c_mul_add_signed: cover property (@(posedge i_clk) mac_go && op_dec == IOD_OP_MUL_ADD_SIGNED);
  c_atomic: cover property (@(posedge i_clk) o_mem_wr);
  c_chain: cover property (@(posedge i_clk) o_interrupt_return_chain);
endmodule : iod_top

/* File: design/iod_pkg.sv */
/*
  iod_pkg: opcode field positions, opcode values, decoded operation
  codes and exception classes for the integer op decoder.
  assumes: 32-bit instruction words, one core clock.
*/
package iod_pkg;
  // field positions
  localparam int OP_HI = 31;
  localparam int OP_LO = 26;
  localparam int RS_HI = 25;
  localparam int RS_LO = 21;
  localparam int RT_HI = 20;
  localparam int RT_LO = 16;
  localparam int RD_HI = 15;
  localparam int RD_LO = 11;
  localparam int FN_HI = 5;
  localparam int FN_LO = 0;
  localparam int CC_BIT_LIKELY = 17;
  localparam int CC_BIT_TRUE = 16;
  localparam int UDI_ROW_HI = 5;
  localparam int UDI_ROW_LO = 4;
  localparam int ACC_LAT = 1;
  localparam int CLZ_LAT = 1;

  // primary opcodes
  localparam logic [5:0] OPC_FUNC = 6'h00;
  localparam logic [5:0] OPC_REG_IMM_GROUP = 6'h01;
  localparam logic [5:0] OPC_J = 6'h02;
  localparam logic [5:0] OPC_JAL = 6'h03;
  localparam logic [5:0] OPC_SYSCP = 6'h10;
  localparam logic [5:0] OPC_CP1 = 6'h11;
  localparam logic [5:0] OPC_USRCP = 6'h12;
  localparam logic [5:0] OPC_CP3 = 6'h13;
  localparam logic [5:0] OPC_EXT2 = 6'h1c;
  localparam logic [5:0] OPC_EXT3 = 6'h1f;

  // ext_group_two functions
  localparam logic [5:0] FN2_MUL_ADD_SIGNED = 6'h00;
  localparam logic [5:0] FN2_MUL_ADD_UNSIGNED = 6'h01;
  localparam logic [5:0] FN2_MUL = 6'h02;
  localparam logic [5:0] FN2_MUL_SUB_SIGNED = 6'h04;
  localparam logic [5:0] FN2_MUL_SUB_UNSIGNED = 6'h05;
  localparam logic [5:0] FN2_CLZ = 6'h20;
  localparam logic [5:0] FN2_CLO = 6'h21;
  localparam logic [5:0] FN2_DBG = 6'h3f;
  localparam logic [1:0] FN2_UDI_ROW = 2'h1;

  // ext_group_three functions
  localparam logic [5:0] FN3_EXTR = 6'h00;
  localparam logic [5:0] FN3_INSR = 6'h04;
  localparam logic [5:0] FN3_SHUF = 6'h20;
  localparam logic [5:0] FN3_HWRD = 6'h3b;

  // sys_coproc functions
  localparam logic [5:0] FN0_TLBRD = 6'h01;
  localparam logic [5:0] FN0_TLBWI = 6'h02;
  localparam logic [5:0] FN0_TLBWRN = 6'h06;
  localparam logic [5:0] FN0_TLBPR = 6'h08;
  localparam logic [5:0] FN0_EXRET = 6'h18;
  localparam logic [5:0] FN0_INTACK = 6'h19;
  localparam logic [5:0] FN0_DBRET = 6'h1f;
  localparam logic [5:0] FN0_WAIT = 6'h20;

  typedef enum logic [2:0] {
    IOD_EXC_NONE = 3'h0,
    IOD_EXC_RSVD = 3'h1,
    IOD_EXC_CPU = 3'h2
  } iod_exc_e;

  typedef enum logic [7:0] {
    IOD_OP_NONE = 8'h00,
    IOD_OP_NOP = 8'h01,
    IOD_OP_SLL = 8'h02,
    IOD_OP_SRL = 8'h03,
    IOD_OP_JR = 8'h04,
    IOD_OP_MFHI = 8'h05,
    IOD_OP_MULT = 8'h06,
    IOD_OP_ADD = 8'h07,
    IOD_OP_FUNC_OTHER = 8'h08,
    IOD_OP_BLTZ = 8'h10,
    IOD_OP_BGEZ = 8'h11,
    IOD_OP_BLTZL = 8'h12,
    IOD_OP_BGEZL = 8'h13,
    IOD_OP_TRAPI = 8'h14,
    IOD_OP_BLTZAL = 8'h15,
    IOD_OP_BGEZAL = 8'h16,
    IOD_OP_BLTZALL = 8'h17,
    IOD_OP_BGEZALL = 8'h18,
    IOD_OP_MUL_ADD_SIGNED = 8'h20,
    IOD_OP_MUL_ADD_UNSIGNED = 8'h21,
    IOD_OP_MUL = 8'h22,
    IOD_OP_MUL_SUB_SIGNED = 8'h23,
    IOD_OP_MUL_SUB_UNSIGNED = 8'h24,
    IOD_OP_CLZ = 8'h25,
    IOD_OP_CLO = 8'h26,
    IOD_OP_DBGBRK = 8'h27,
    IOD_OP_UDI = 8'h28,
    IOD_OP_EXTR = 8'h30,
    IOD_OP_INSR = 8'h31,
    IOD_OP_SHUF = 8'h32,
    IOD_OP_HWRD = 8'h33,
    IOD_OP_MFC2 = 8'h40,
    IOD_OP_CFC2 = 8'h41,
    IOD_OP_MFHC2 = 8'h42,
    IOD_OP_MTC2 = 8'h43,
    IOD_OP_CTC2 = 8'h44,
    IOD_OP_MTHC2 = 8'h45,
    IOD_OP_BC2F = 8'h46,
    IOD_OP_BC2T = 8'h47,
    IOD_OP_BC2FL = 8'h48,
    IOD_OP_BC2TL = 8'h49,
    IOD_OP_USER_COPROC = 8'h4a,
    IOD_OP_MFC0 = 8'h50,
    IOD_OP_MTC0 = 8'h51,
    IOD_OP_RDPGPR = 8'h52,
    IOD_OP_INTEN = 8'h53,
    IOD_OP_WRPGPR = 8'h54,
    IOD_OP_TLBR = 8'h55,
    IOD_OP_TLBWI = 8'h56,
    IOD_OP_TLBWR = 8'h57,
    IOD_OP_TLBP = 8'h58,
    IOD_OP_EXCEPTION_RETURN = 8'h59,
    IOD_OP_INTERRUPT_RETURN = 8'h5a,
    IOD_OP_DEBUG_RETURN = 8'h5b,
    IOD_OP_WAIT = 8'h5c,
    IOD_OP_OTHER = 8'h60
  } iod_op_e;

  typedef enum logic [2:0] {
    IOD_AT_IDLE = 3'b001,
    IOD_AT_READ = 3'b010,
    IOD_AT_WRITE = 3'b100
  } iod_at_e;
endpackage : iod_pkg

/* File: design/iod_clz.sv */
`timescale 1ns/1ps
/*
  iod_clz: registered leading-zero/one counter over one 32-bit word.
  assumes: operand stable in the cycle before o_count is sampled by the caller.
*/
module iod_clz
  import iod_pkg::*;
#(
  parameter int W = 32
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_word,
  input wire logic i_ones,
  output logic [5:0] o_count
);
  function automatic logic [5:0] lead_zeros(input logic [W-1:0] v);
    logic [5:0] n;
    logic hit;
    n = 6'h00;
    hit = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      if (!hit && !v[i]) begin
        n = n + 6'h01;
      end else begin
        hit = 1'b1;
      end
    end
    return n;
  endfunction : lead_zeros

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_count <= 6'h00;
    end else begin
      // counting ones reuses the zero scan on the inverted word
      o_count <= lead_zeros(i_ones ? ~i_word : i_word);
    end
  end
endmodule : iod_clz

/* File: design/iod_mac.sv */
`timescale 1ns/1ps
/*
  iod_mac: 64-bit product pair with multiply, accumulate and subtract.
  assumes: one request pulse per operation, operands valid with it.
*/
module iod_mac
  import iod_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_go,
  input wire logic i_signed,
  input wire logic i_sub,
  input wire logic i_acc,
  input wire logic [31:0] i_a,
  input wire logic [31:0] i_b,
  output logic [31:0] o_hi,
  output logic [31:0] o_lo
);
  logic [63:0] prod;
  logic [63:0] acc_next;

  always_comb begin
    if (i_signed) begin
      prod = 64'($signed(i_a) * $signed(i_b));
    end else begin
      prod = 64'({32'h0, i_a} * {32'h0, i_b});
    end
    // wraps modulo 2^64, no overflow flag exists to raise
    if (!i_acc) begin
      acc_next = prod;
    end else if (i_sub) begin
      acc_next = {o_hi, o_lo} - prod;
    end else begin
      acc_next = {o_hi, o_lo} + prod;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_hi <= 32'h0;
      o_lo <= 32'h0;
    end else if (i_go) begin
      o_hi <= acc_next[63:32];
      o_lo <= acc_next[31:0];
    end
  end
endmodule : iod_mac

/* File: verif/iod_mem_model.sv */
/*
  iod_mem_model: byte data port answering the atomic bit sequencer.
  assumes: read request is a level held until the ack pulse.
*/
`timescale 1ns/1ps
module iod_mem_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_rd,
  input wire logic [3:0] i_delay,
  input wire logic [7:0] i_data,
  output logic o_ack,
  output logic [7:0] o_rdata
);
  logic [3:0] wait_reg;
  logic fire;
  assign fire = i_rd && !o_ack && (wait_reg >= i_delay);
  // ack after i_delay idle cycles, one cycle wide
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_ack <= 1'b0;
      wait_reg <= 4'h0;
    end else begin
      o_ack <= fire;
      wait_reg <= (i_rd && !fire) ? wait_reg + 4'h1 : 4'h0;
    end
  end
  // stale byte toggles so a late sample never matches
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= fire ? i_data : ~o_rdata;
    end
  end
endmodule : iod_mem_model

/* File: verif/tb.sv */
/*
  tb: self-checking bench for iod_top.
  assumes: fetch side driven at falling edges, memory model on data port.
*/
`timescale 1ns/1ps
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin n_fail++; $display("Error %s exp %0h got %0h", nm, e, s); end end
module tb
  import iod_pkg::*;
;
  logic i_clk = 0, i_nrst = 0, i_valid = 0, i_irq_pending = 0;
  logic [31:0] i_instr = 0, i_src_a = 0, i_src_b = 0;
  logic [7:0] i_mem_rdata, o_mem_wdata, mdata = 0;
  logic i_mem_ack, o_ready, o_result_we, o_irq_block, o_interrupt_return_restore, o_interrupt_return_chain, o_mem_rd, o_mem_wr;
  logic [31:0] o_result, o_prod_high, o_prod_low;
  logic [3:0] delay = 0;
  logic [63:0] acc = 0;
  iod_op_e o_op;
  iod_exc_e o_exc;
  int n_fail = 0, num_checks = 0, cyc = 0;

  always #12.5 i_clk = ~i_clk;

  iod_top #(.HAS_UDI(1'b0), .HAS_CHAIN(1'b1)) dut_u (.i_clk, .i_nrst, .i_valid, .i_instr, .i_src_a,
    .i_src_b, .i_irq_pending, .i_mem_rdata, .i_mem_ack, .o_ready, .o_op, .o_exc, .o_result,
    .o_result_we, .o_prod_high, .o_prod_low, .o_irq_block, .o_interrupt_return_restore, .o_interrupt_return_chain,
    .o_mem_rd, .o_mem_wr, .o_mem_wdata);
  iod_mem_model mem_u (.i_clk, .i_nrst, .i_rd(o_mem_rd), .i_delay(delay), .i_data(mdata),
    .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));

  function automatic logic [31:0] bit_insert(input logic [5:0] op, input logic [4:0] rs, input logic [4:0] rt,
      input logic [5:0] fn);
    return {op, rs, rt, 10'h0, fn};
  endfunction : bit_insert

  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  // one word per call; waits out bubbles, samples the answer cycle
  task automatic issue(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b);
    int k;
    k = 0;
    // one edge passes between words so valid never drops and rises in one step
    @(negedge i_clk);
    while (o_ready !== 1'b1 && k < 50) begin
      @(negedge i_clk);
      k++;
    end
    i_instr = w;
    i_src_a = a;
    i_src_b = b;
    i_valid = 1'b1;
    @(negedge i_clk);
    i_valid = 1'b0;
  endtask : issue

  task automatic mac(input logic [5:0] fn, input logic [31:0] a, input logic [31:0] b);
    logic [63:0] p;
    p = (fn == FN2_MUL_ADD_SIGNED || fn == FN2_MUL_SUB_SIGNED) ? {{32{a[31]}}, a} * {{32{b[31]}}, b} : {32'h0, a} * {32'h0, b};
    acc = fn[2] ? acc - p : acc + p;
    issue(bit_insert(OPC_EXT2, 5'h1, 5'h2, fn), a, b);
    `CHK("pair", acc, {o_prod_high, o_prod_low})
    `CHK("mac_exc", IOD_EXC_NONE, o_exc)
  endtask : mac

  task automatic t_mac();
    `CHK("pair_rst", 64'h0, {o_prod_high, o_prod_low})
    mac(FN2_MUL_ADD_SIGNED, 32'hfffffffe, 32'h3);
    mac(FN2_MUL_ADD_UNSIGNED, 32'hffffffff, 32'hffffffff);
    mac(FN2_MUL_SUB_SIGNED, 32'h80000000, 32'h80000000);
    mac(FN2_MUL_SUB_UNSIGNED, 32'hffffffff, 32'h2);
    mac(FN2_MUL_ADD_SIGNED, 32'h7fffffff, 32'h80000000);
  endtask : t_mac

  task automatic cnt(input logic [5:0] fn, input logic [31:0] a, input logic [31:0] e);
    issue(bit_insert(OPC_EXT2, 5'h3, 5'h0, fn), a, 32'h0);
    `CHK("count", e, o_result)
    `CHK("count_we", 1'b1, o_result_we)
  endtask : cnt

  task automatic t_count();
    cnt(FN2_CLZ, 32'h0, 32'd32);
    cnt(FN2_CLZ, 32'h1, 32'd31);
    cnt(FN2_CLZ, 32'h80000000, 32'd0);
    cnt(FN2_CLZ, 32'h00010000, 32'd15);
    cnt(FN2_CLO, 32'hffffffff, 32'd32);
    cnt(FN2_CLO, 32'hf0000000, 32'd4);
  endtask : t_count

  task automatic t_mul();
    issue(bit_insert(OPC_EXT2, 5'h1, 5'h2, FN2_MUL), 32'hfffffffd, 32'h7);
    `CHK("mul_lo", 32'hffffffeb, o_result)
    issue(bit_insert(OPC_EXT2, 5'h1, 5'h2, FN2_MUL), 32'h80000000, 32'h80000000);
    `CHK("mul_lo", 32'h0, o_result)
    `CHK("mul_exc", IOD_EXC_NONE, o_exc)
  endtask : t_mul

  task automatic dec(input logic [31:0] w, input iod_op_e op, input iod_exc_e ex);
    issue(w, 32'h0, 32'h0);
    `CHK("exc", ex, o_exc)
    `CHK("op", op, o_op)
  endtask : dec

  task automatic t_rst();
    i_nrst = 1'b0;
    @(negedge i_clk);
    `CHK("pair_clr", 64'h0, {o_prod_high, o_prod_low})
    `CHK("rst_ready", 1'b1, o_ready)
    `CHK("rst_op", IOD_OP_NONE, o_op)
    i_nrst = 1'b1;
  endtask : t_rst

  task automatic t_interrupt_return();
    i_irq_pending = 1'b1;
    dec(bit_insert(OPC_SYSCP, 5'h10, 5'h0, FN0_INTACK), IOD_OP_INTERRUPT_RETURN, IOD_EXC_NONE);
    `CHK("interrupt_return_restore", 1'b1, o_interrupt_return_restore)
    `CHK("interrupt_return_chain", 1'b1, o_interrupt_return_chain)
    i_irq_pending = 1'b0;
    dec(bit_insert(OPC_SYSCP, 5'h10, 5'h0, FN0_INTACK), IOD_OP_INTERRUPT_RETURN, IOD_EXC_NONE);
    `CHK("interrupt_return_restore", 1'b1, o_interrupt_return_restore)
    `CHK("interrupt_return_nochain", 1'b0, o_interrupt_return_chain)
  endtask : t_interrupt_return

  task automatic t_decode();
    dec(32'h0, IOD_OP_NOP, IOD_EXC_NONE);
    dec(32'h40, IOD_OP_NOP, IOD_EXC_NONE);
    `CHK("nop_ready", 1'b1, o_ready)
    dec(bit_insert(OPC_FUNC, 5'h1, 5'h2, 6'h20), IOD_OP_ADD, IOD_EXC_NONE);
    dec(bit_insert(OPC_FUNC, 5'h1, 5'h0, 6'h08), IOD_OP_JR, IOD_EXC_NONE);
    dec(bit_insert(OPC_CP1, 5'h0, 5'h0, 6'h0), IOD_OP_NONE, IOD_EXC_CPU);
    dec(bit_insert(OPC_CP3, 5'h0, 5'h0, 6'h0), IOD_OP_NONE, IOD_EXC_CPU);
    dec(bit_insert(6'h18, 5'h0, 5'h0, 6'h0), IOD_OP_NONE, IOD_EXC_RSVD);
    dec(bit_insert(6'h1d, 5'h0, 5'h0, 6'h0), IOD_OP_OTHER, IOD_EXC_NONE);
    dec(bit_insert(OPC_EXT2, 5'h0, 5'h0, 6'h10), IOD_OP_NONE, IOD_EXC_RSVD);
    dec(bit_insert(OPC_EXT2, 5'h0, 5'h0, FN2_DBG), IOD_OP_DBGBRK, IOD_EXC_NONE);
    dec(bit_insert(OPC_EXT3, 5'h0, 5'h0, FN3_HWRD), IOD_OP_HWRD, IOD_EXC_NONE);
    dec(bit_insert(OPC_EXT3, 5'h0, 5'h0, FN3_SHUF), IOD_OP_SHUF, IOD_EXC_NONE);
    dec(bit_insert(OPC_EXT3, 5'h0, 5'h0, 6'h01), IOD_OP_NONE, IOD_EXC_RSVD);
    dec(bit_insert(OPC_REG_IMM_GROUP, 5'h0, 5'h11, 6'h0), IOD_OP_BGEZAL, IOD_EXC_NONE);
    dec(bit_insert(OPC_REG_IMM_GROUP, 5'h0, 5'h08, 6'h0), IOD_OP_TRAPI, IOD_EXC_NONE);
    dec(bit_insert(OPC_USRCP, 5'h08, 5'h03, 6'h0), IOD_OP_BC2TL, IOD_EXC_NONE);
    dec(bit_insert(OPC_USRCP, 5'h0f, 5'h00, 6'h0), IOD_OP_BC2F, IOD_EXC_NONE);
    dec(bit_insert(OPC_USRCP, 5'h04, 5'h0, 6'h0), IOD_OP_MTC2, IOD_EXC_NONE);
    dec(bit_insert(OPC_SYSCP, 5'h0b, 5'h0, 6'h0), IOD_OP_INTEN, IOD_EXC_NONE);
    dec(bit_insert(OPC_SYSCP, 5'h10, 5'h0, FN0_EXRET), IOD_OP_EXCEPTION_RETURN, IOD_EXC_NONE);
    dec(bit_insert(OPC_SYSCP, 5'h10, 5'h0, FN0_WAIT), IOD_OP_WAIT, IOD_EXC_NONE);
  endtask : t_decode

  task automatic t_atom(input logic [5:0] fn, input logic [2:0] bn, input logic [7:0] rd,
      input logic [7:0] e, input logic [3:0] dly);
    int k;
    delay = dly;
    mdata = rd;
    i_irq_pending = 1'b1;
    issue(bit_insert(OPC_EXT3, 5'h0, 5'h0, fn) | {18'h0, bn, 11'h0}, 32'h0, 32'h0);
    k = 0;
    while (o_mem_wr !== 1'b1 && k < 40) begin
      `CHK("irq_block", 1'b1, o_irq_block)
      `CHK("mem_rd", 1'b1, o_mem_rd)
      @(negedge i_clk);
      k++;
    end
    `CHK("wdata", e, o_mem_wdata)
    `CHK("wr_block", 1'b1, o_irq_block)
    @(negedge i_clk);
    i_irq_pending = 1'b0;
    `CHK("wr_once", 1'b0, o_mem_wr)
  endtask : t_atom

  // hang guard, far above the hundred or so cycles the run needs
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      results();
    end
  end

  initial begin
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    i_nrst = 1'b1;
    t_mac();
    t_count();
    t_mul();
    t_rst();
    t_decode();
    t_interrupt_return();
    t_atom(6'h3c, 3'h3, 8'hff, 8'hf7, 4'h0);
    t_atom(6'h3d, 3'h7, 8'h00, 8'h80, 4'h5);
    results();
  end
endmodule : tb
